// ### include/smsc_pkg.sv
// Shared constants and types for the switch monitor serial configuration block.
// Assumes a single 24-bit frame format and the register layout used by rtl/ files.
`default_nettype none
package smsc_pkg;
   localparam int N_PROG = 8;
   localparam int N_GND = 14;
   localparam int N_SW = N_PROG + N_GND;
   localparam int FRAME_BITS = 24;
   localparam int CMD_HI = 23;
   localparam int CMD_LO = 16;
   localparam int STAT_THERM = 23;
   localparam int STAT_INT = 22;
   localparam int CNT_W = 7;
   localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
   localparam logic [CNT_W-1:0] CNT_ONE_FRAME = 7'h18;
   localparam logic [CNT_W-1:0] CNT_TWO_FRAMES = 7'h30;
   localparam logic [CNT_W-1:0] CNT_MAX = 7'h7F;
   localparam logic [7:0] CMD_BAT_GND_SEL = 8'h01;
   localparam logic [7:0] CMD_WAKE_PROG = 8'h02;
   localparam logic [7:0] CMD_WAKE_GND = 8'h03;
   localparam logic [7:0] CMD_CUR_PROG = 8'h04;
   localparam logic [7:0] CMD_CUR_GND = 8'h05;
   localparam logic [N_PROG-1:0] BG_RESET = 8'hFF;
   localparam logic [N_PROG-1:0] WAKE_PROG_RESET = 8'hFF;
   localparam logic [N_GND-1:0] WAKE_GND_RESET = 14'h3FFF;
   localparam logic [N_PROG-1:0] CUR_PROG_RESET = 8'hFF;
   localparam logic [N_GND-1:0] CUR_GND_RESET = 14'h3FFF;
   localparam int SYNC_W = N_SW + 4;
   localparam int SY_CS = N_SW;
   localparam int SY_WAKE = N_SW + 1;
   localparam int SY_INT = N_SW + 2;
   localparam int SY_VDD = N_SW + 3;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 26'h1C00000;
   typedef enum {MODE_NORMAL, MODE_SLEEP} smsc_mode_t;
endpackage
`default_nettype wire

// ### rtl/smsc_sync.sv
// Three-stage synchroniser for pin inputs, one lane per bit.
// Output moves only when stages two and three agree; inputs are asynchronous to clk_sys.
`default_nettype none
module smsc_sync import smsc_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [SYNC_W-1:0] din,
   output logic [SYNC_W-1:0] dout
);
   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_lane
         logic s1, s2, s3, q, next_q;
         always_comb begin
            next_q = (s2 == s3) ? s3 : q;
         end
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               s1 <= SYNC_RESET[i];
               s2 <= SYNC_RESET[i];
               s3 <= SYNC_RESET[i];
               q <= SYNC_RESET[i];
            end else begin
               s1 <= din[i];
               s2 <= s1;
               s3 <= s2;
               q <= next_q;
            end
         end
         assign dout[i] = q;
      end
   endgenerate
endmodule
`default_nettype wire

// ### rtl/smsc_spi_link.sv
// Shift logic clocked by the serial clock itself.
// Assumes the serial clock is low at every chip-select edge and stands still outside frames.
`default_nettype none
module smsc_spi_link import smsc_pkg::*; (
   input wire logic sclkLink,
   input wire logic reset_n,
   input wire logic csLink_n,
   input wire logic si,
   input wire logic [FRAME_BITS-1:0] txWord,
   output logic [FRAME_BITS-1:0] rxWord,
   output logic [CNT_W-1:0] bitCount,
   output logic rxFresh,
   output logic soData
);
   logic txFirst, csTog, next_csTog, clkTog, next_clkTog;
   logic [FRAME_BITS-1:0] txShift, next_txShift, next_rxWord;
   logic [CNT_W-1:0] next_bitCount;

   // Each select fall flips csTog and the frame's first clock fall copies it, so a frame
   // with no clocks still reads fresh after its own select rise and cannot reuse an old count
   always_comb begin
      next_csTog = ~csTog;
   end

   always_ff @(negedge csLink_n or negedge reset_n) begin
      if (!reset_n) begin
         csTog <= 1'b0;
      end else begin
         csTog <= next_csTog;
      end
   end

   assign rxFresh = csTog ^ clkTog;

   always_comb begin
      next_rxWord = rxWord;
      next_bitCount = bitCount;
      next_clkTog = clkTog;
      if (!csLink_n) begin
         next_clkTog = csTog;
         next_rxWord = {rxWord[FRAME_BITS-2:0], si};
         if (rxFresh) begin
            next_bitCount = CNT_ONE;
         end else if (bitCount != CNT_MAX) begin
            next_bitCount = bitCount + CNT_ONE;
         end
      end
   end

   // Word and count are left standing after the frame for the system side to read
   always_ff @(negedge sclkLink or negedge reset_n) begin
      if (!reset_n) begin
         rxWord <= '0;
         bitCount <= CNT_ZERO;
         clkTog <= 1'b0;
      end else begin
         rxWord <= next_rxWord;
         bitCount <= next_bitCount;
         clkTog <= next_clkTog;
      end
   end

   always_ff @(posedge sclkLink or posedge csLink_n or negedge reset_n) begin
      if (!reset_n) begin
         txFirst <= 1'b1;
      end else if (csLink_n) begin
         txFirst <= 1'b1;
      end else begin
         txFirst <= 1'b0;
      end
   end

   always_comb begin
      next_txShift = txShift;
      if (!csLink_n) begin
         // First rising edge loads the status; later ones pass input bits on for chaining
         next_txShift = txFirst ? txWord : {txShift[FRAME_BITS-2:0], rxWord[0]};
      end
   end

   always_ff @(posedge sclkLink or negedge reset_n) begin
      if (!reset_n) begin
         txShift <= '0;
      end else begin
         txShift <= next_txShift;
      end
   end

   assign soData = txShift[FRAME_BITS-1];
endmodule
`default_nettype wire

// ### rtl/smsc_top.sv
// Serial command interpreter, configuration store and mode control of the switch monitor.
// Assumes analog comparators on the inputs, an external sleep request and interrupt timer.
//
// Notes on behaviour
// - Every frame shifts out switch status, interrupt flag and thermal flag.
// - Switch states are captured into the output word at chip-select fall.
// - A frame is twenty-four serial clocks with chip select low.
// - Losing the interface supply in normal mode keeps normal mode.
// - Losing it in sleep keeps sleep until wake pin, enabled change or timer.
// - Without interface supply, no serial traffic, and alert and select cannot wake.
// - Battery power-on reset leaves the device in normal mode.
// - Reset defaults: battery select, all wake enabled, 16 mA current.
// - Normal mode entered by power-up, change, wake, alert, select or timer.
// - Register writes only in normal mode with interface supply present.
// - Alert released at select rise unless a change came while select was low.
// - Code 01 loads battery/ground select of programmable inputs, one means battery.
// - A closed switch always reports one, whatever its select.
// - Codes 02 and 03 load wake/interrupt enables; zero blocks both.
// - Codes 04 and 05 load contact current; zero is 2 mA, one 16 mA.
// - Configuration commands may come in any order at any time in normal mode.
// - Input sampled on falling clock, output changed on rising clock.
// - With select high, clock and input are ignored and output is released.
// - Words travel most significant bit first.
// - A received command takes effect only at select rise.
`default_nettype none
module smsc_top import smsc_pkg::*; (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic sclkLink,
   input wire logic csPin_n,
   input wire logic siPin,
   output logic soOut,
   output logic soEnable_n,
   input wire logic intIn,
   output logic intOut,
   output logic intOe_n,
   input wire logic wakeIn,
   output logic wakeOut,
   output logic wakeOe_n,
   input wire logic vddPresent,
   input wire logic [N_PROG-1:0] progAboveRef,
   input wire logic [N_GND-1:0] groundAboveRef,
   input wire logic thermalFlag,
   input wire logic sleepRequest,
   input wire logic intTimerExpired,
   output logic normalMode,
   output logic [N_PROG-1:0] batGndSelect,
   output logic [N_PROG-1:0] wakeEnProg,
   output logic [N_GND-1:0] wakeEnGnd,
   output logic [N_PROG-1:0] currentProg,
   output logic [N_GND-1:0] currentGnd
);
   logic [SYNC_W-1:0] syncIn, syncOut, prevSync;
   logic [FRAME_BITS-1:0] rxWord, snapshot, next_snapshot;
   logic [CNT_W-1:0] bitCount;
   logic rxFresh, soData;
   logic csLow, vddOk, wakeHigh, intHigh;
   logic csFall, csRise, wakeFall, intFall;
   logic [N_PROG-1:0] closedProg;
   logic [N_GND-1:0] closedGnd;
   logic [N_SW-1:0] closedAll, prevClosed, changeVec;
   logic enChange, frameLenOk, writeStrobe, wakeEvent;
   smsc_mode_t mode, next_mode;
   logic intFlag, next_intFlag, changeInCs, next_changeInCs;
   logic [N_PROG-1:0] next_batGndSelect, next_wakeEnProg, next_currentProg;
   logic [N_GND-1:0] next_wakeEnGnd, next_currentGnd;

   assign syncIn = {vddPresent, intIn, wakeIn, csPin_n, groundAboveRef, progAboveRef};

   smsc_sync u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .din(syncIn),
      .dout(syncOut)
   );

   // Snapshot is frozen while select is low, so the link reads a settled word
   smsc_spi_link u_link (
      .sclkLink(sclkLink),
      .reset_n(reset_n),
      .csLink_n(csPin_n),
      .si(siPin),
      .txWord(snapshot),
      .rxWord(rxWord),
      .bitCount(bitCount),
      .rxFresh(rxFresh),
      .soData(soData)
   );

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prevSync <= SYNC_RESET;
      end else begin
         prevSync <= syncOut;
      end
   end

   assign csLow = ~syncOut[SY_CS];
   assign vddOk = syncOut[SY_VDD];
   assign wakeHigh = syncOut[SY_WAKE];
   assign intHigh = syncOut[SY_INT];
   assign csFall = prevSync[SY_CS] & ~syncOut[SY_CS];
   assign csRise = ~prevSync[SY_CS] & syncOut[SY_CS];
   assign wakeFall = prevSync[SY_WAKE] & ~wakeHigh;
   assign intFall = prevSync[SY_INT] & ~intHigh;

   // Closed switches read as one regardless of their battery/ground select
   assign closedProg = ~(batGndSelect ^ syncOut[N_PROG-1:0]);
   assign closedGnd = ~syncOut[N_SW-1:N_PROG];
   assign closedAll = {closedGnd, closedProg};
   assign changeVec = closedAll ^ prevClosed;
   assign enChange = |(changeVec & {wakeEnGnd, wakeEnProg});

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prevClosed <= '0;
      end else begin
         prevClosed <= closedAll;
      end
   end

   // Output word: switch states plus flags, taken once per frame
   always_comb begin
      next_snapshot = snapshot;
      if (csFall && vddOk) begin
         next_snapshot = {thermalFlag, intFlag | enChange, closedGnd, closedProg};
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         snapshot <= '0;
      end else begin
         snapshot <= next_snapshot;
      end
   end

   // Chained devices see two frames of clocks; the last 24 bits are ours
   assign frameLenOk = (bitCount == CNT_ONE_FRAME) || (bitCount == CNT_TWO_FRAMES);
   assign writeStrobe = csRise && vddOk && (mode == MODE_NORMAL) && !rxFresh && frameLenOk;

   always_comb begin
      next_batGndSelect = batGndSelect;
      next_wakeEnProg = wakeEnProg;
      next_wakeEnGnd = wakeEnGnd;
      next_currentProg = currentProg;
      next_currentGnd = currentGnd;
      if (writeStrobe) begin
         // Only the code and the data field are decoded
         case (rxWord[CMD_HI:CMD_LO])
            CMD_BAT_GND_SEL: next_batGndSelect = rxWord[N_PROG-1:0];
            CMD_WAKE_PROG: next_wakeEnProg = rxWord[N_PROG-1:0];
            CMD_WAKE_GND: next_wakeEnGnd = rxWord[N_GND-1:0];
            CMD_CUR_PROG: next_currentProg = rxWord[N_PROG-1:0];
            CMD_CUR_GND: next_currentGnd = rxWord[N_GND-1:0];
            default: next_batGndSelect = batGndSelect;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         batGndSelect <= BG_RESET;
         wakeEnProg <= WAKE_PROG_RESET;
         wakeEnGnd <= WAKE_GND_RESET;
         currentProg <= CUR_PROG_RESET;
         currentGnd <= CUR_GND_RESET;
      end else begin
         batGndSelect <= next_batGndSelect;
         wakeEnProg <= next_wakeEnProg;
         wakeEnGnd <= next_wakeEnGnd;
         currentProg <= next_currentProg;
         currentGnd <= next_currentGnd;
      end
   end

   // Alert flag: a change in the same cycle as the select rise still wins
   always_comb begin
      next_intFlag = intFlag;
      next_changeInCs = changeInCs;
      if (csFall) begin
         next_changeInCs = 1'b0;
      end
      if (enChange && csLow) begin
         next_changeInCs = 1'b1;
      end
      if (csRise && vddOk && !changeInCs) begin
         next_intFlag = 1'b0;
      end
      if (enChange) begin
         next_intFlag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         intFlag <= 1'b0;
         changeInCs <= 1'b0;
      end else begin
         intFlag <= next_intFlag;
         changeInCs <= next_changeInCs;
      end
   end

   // Select and alert edges count only with the interface supply up
   assign wakeEvent = enChange | wakeFall | intTimerExpired | (csFall & vddOk)
      | (intFall & vddOk & wakeHigh);

   always_comb begin
      case (mode)
         MODE_NORMAL: next_mode = sleepRequest ? MODE_SLEEP : MODE_NORMAL;
         MODE_SLEEP: next_mode = wakeEvent ? MODE_NORMAL : MODE_SLEEP;
         default: next_mode = MODE_NORMAL;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= MODE_NORMAL;
      end else begin
         mode <= next_mode;
      end
   end

   assign normalMode = (mode == MODE_NORMAL);
   assign soOut = soData;
   // Released asynchronously from the pin so no clock is needed to let go of the line
   assign soEnable_n = csPin_n | ~vddOk;
   assign intOut = 1'b0;
   assign intOe_n = ~intFlag;
   assign wakeOut = 1'b0;
   assign wakeOe_n = (mode != MODE_NORMAL);

   sequence seqCsRiseOk;
      csRise && vddOk && !rxFresh;
   endsequence

   sequence seqGoodFrameEnd;
      seqCsRiseOk ##0 frameLenOk && normalMode;
   endsequence

   chk_write_needs_normal: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !$stable(batGndSelect) || !$stable(wakeEnGnd) || !$stable(currentGnd)
      |-> $past(normalMode) && $past(vddOk) && $past(csRise))
      else $error("Configuration changed outside a normal-mode frame end");

   chk_bad_length_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
      csRise && !frameLenOk |=> $stable(batGndSelect) && $stable(wakeEnProg) && $stable(currentProg))
      else $error("Frame of wrong length changed configuration");

   chk_bat_gnd_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      seqGoodFrameEnd ##0 rxWord[CMD_HI:CMD_LO] == CMD_BAT_GND_SEL |=> batGndSelect == $past(rxWord[N_PROG-1:0]))
      else $error("Battery/ground select not loaded");

   chk_wake_gnd_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      seqGoodFrameEnd ##0 rxWord[CMD_HI:CMD_LO] == CMD_WAKE_GND |=> wakeEnGnd == $past(rxWord[N_GND-1:0]))
      else $error("Ground-input wake enable not loaded");

   chk_wake_prog_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      seqGoodFrameEnd ##0 rxWord[CMD_HI:CMD_LO] == CMD_WAKE_PROG |=> wakeEnProg == $past(rxWord[N_PROG-1:0]))
      else $error("Programmable-input wake enable not loaded");

   chk_cur_gnd_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      seqGoodFrameEnd ##0 rxWord[CMD_HI:CMD_LO] == CMD_CUR_GND |=> currentGnd == $past(rxWord[N_GND-1:0]))
      else $error("Ground-input current not loaded");

   chk_current_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      seqGoodFrameEnd ##0 rxWord[CMD_HI:CMD_LO] == CMD_CUR_PROG |=> currentProg == $past(rxWord[N_PROG-1:0]))
      else $error("Programmable-input current not loaded");

   chk_snapshot_capture: assert property (@(posedge clk_sys) disable iff (!reset_n)
      csFall && vddOk |=> snapshot[N_SW-1:0] == $past(closedAll) && snapshot[STAT_THERM] == $past(thermalFlag))
      else $error("Status word not captured at select fall");

   chk_alert_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
      csRise && vddOk && !changeInCs && !enChange |=> !intFlag && intOe_n)
      else $error("Alert not released at select rise");

   chk_change_in_frame: assert property (@(posedge clk_sys) disable iff (!reset_n)
      csLow && enChange |=> changeInCs && intFlag)
      else $error("Change during frame not remembered");

   chk_alert_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      csRise && changeInCs |=> intFlag)
      else $error("Alert released despite change during frame");

   chk_sleep_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !normalMode && !vddOk && !enChange && !wakeFall && !intTimerExpired |=> !normalMode)
      else $error("Left sleep without a permitted wake source");

   chk_wake_on_change: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !normalMode && enChange |=> normalMode && !wakeOe_n)
      else $error("Enabled change did not wake the device");

   chk_normal_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
      normalMode && !sleepRequest |=> normalMode)
      else $error("Left normal mode without a sleep request");
endmodule
`default_nettype wire

// ### verif/smsc_host_model.sv
// Host-side serial master model for the switch monitor.
// Assumes the bench calls its tasks in order: start, shift, stop.
`default_nettype none
module smsc_host_model (
   output logic sclkLink,
   output logic csPin_n,
   output logic siPin,
   input wire logic soOut,
   input wire logic soEnable_n
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      sclkLink = 1'b0;
      csPin_n = 1'b1;
      siPin = 1'b0;
   end
   // Clock is low at the select edge; snapshot needs 5 system cycles
   task automatic start();
      csPin_n = 1'b0;
      #40;
   endtask
   // Clock only runs inside frames, 12 ns per bit
   task automatic shift(input int n, input logic [47:0] din, output logic [47:0] dout);
      dout = '0;
      for (int i = n - 1; i >= 0; i--) begin
         // Data moves 1 ns after the falling edge, so that edge still samples the old bit
         #1 siPin = din[i];
         #5 sclkLink = 1'b1;
         #6 sclkLink = 1'b0;
         dout = {dout[46:0], soOut};
      end
      #1 siPin = ~siPin;
   endtask
   // Leaves the select high long enough to be applied
   task automatic stop();
      #3 csPin_n = 1'b1;
      #60;
   endtask
endmodule
`default_nettype wire

// ### verif/test_switch_monitor_spi_config.sv
// Self-checking bench for the switch monitor serial block.
// Assumes the host model drives the serial pins; open-drain wires resolved here.
`default_nettype none
module test_switch_monitor_spi_config import smsc_pkg::*; ();
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, reset_n, sclkLink, csPin_n, siPin, soOut, soEnable_n;
   logic intOe_n, wakeOe_n, intExt, wakeExt, vddPresent, normalMode;
   logic thermalFlag, sleepRequest, intTimerExpired;
   logic [N_PROG-1:0] progAboveRef, batGndSelect, wakeEnProg, currentProg;
   logic [N_GND-1:0] groundAboveRef, wakeEnGnd, currentGnd;
   logic [47:0] rx;
   int failures, tests_run;
   wire intIn = intOe_n & intExt;
   wire wakeIn = wakeOe_n & wakeExt;
   smsc_host_model host (.sclkLink(sclkLink), .csPin_n(csPin_n), .siPin(siPin),
      .soOut(soOut), .soEnable_n(soEnable_n));
   smsc_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .sclkLink(sclkLink), .csPin_n(csPin_n),
      .siPin(siPin), .soOut(soOut), .soEnable_n(soEnable_n), .intIn(intIn), .intOut(),
      .intOe_n(intOe_n), .wakeIn(wakeIn), .wakeOut(), .wakeOe_n(wakeOe_n),
      .vddPresent(vddPresent), .progAboveRef(progAboveRef), .groundAboveRef(groundAboveRef),
      .thermalFlag(thermalFlag), .sleepRequest(sleepRequest), .intTimerExpired(intTimerExpired),
      .normalMode(normalMode), .batGndSelect(batGndSelect), .wakeEnProg(wakeEnProg),
      .wakeEnGnd(wakeEnGnd), .currentProg(currentProg), .currentGnd(currentGnd));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic drv();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic frame(input int n, input logic [47:0] din);
      host.start();
      host.shift(n, din, rx);
      host.stop();
   endtask
   function automatic logic [13:0] cfg(input logic [7:0] c);
      case (c)
         CMD_BAT_GND_SEL: return {6'h00, batGndSelect};
         CMD_WAKE_PROG: return {6'h00, wakeEnProg};
         CMD_WAKE_GND: return wakeEnGnd;
         CMD_CUR_PROG: return {6'h00, currentProg};
         default: return currentGnd;
      endcase
   endfunction
   // Bounded wait on the alert output
   task automatic waitAlert(input logic lvl);
      for (int i = 0; i < 20 && intOe_n !== lvl; i++)
         @(posedge clk_sys);
      check(intOe_n, lvl, "alert level");
      if (intOe_n !== lvl)
         complete_run();
   endtask
   task automatic testWrites();
      logic [7:0] codes [5] = '{CMD_CUR_GND, CMD_CUR_PROG, CMD_WAKE_GND, CMD_WAKE_PROG, CMD_BAT_GND_SEL};
      logic [13:0] d, old;
      foreach (codes[k]) begin
         d = 14'h2A5A + 14'(k * 7);
         old = cfg(codes[k]);
         host.start();
         host.shift(24, {24'h0, codes[k], 2'b11, d}, rx);
         check(cfg(codes[k]), old, "held until select rise");
         host.stop();
         check(cfg(codes[k]), codes[k][0] && codes[k] != 8'h01 ? d : {6'h00, d[7:0]}, "write");
      end
      frame(23, {24'h0, CMD_CUR_PROG, 16'h0011});
      frame(25, {24'h0, CMD_CUR_PROG, 16'h0011});
      check(currentProg, 8'h5A + 8'h07, "odd count refused");
      $display("write test done");
   endtask
   task automatic testStatus();
      frame(24, {24'h0, CMD_WAKE_GND, 16'h0000});
      frame(24, {24'h0, CMD_WAKE_PROG, 16'h0000});
      frame(24, {24'h0, CMD_BAT_GND_SEL, 16'h00F0});
      drv();
      progAboveRef = 8'h3C;
      groundAboveRef = 14'h0F0F;
      thermalFlag = 1'b1;
      repeat (10) @(posedge clk_sys);
      host.start();
      drv();
      progAboveRef = 8'hC3;
      groundAboveRef = 14'h30F0;
      host.shift(24, 48'h0, rx);
      host.stop();
      check(rx[23:0], {1'b1, 1'b0, ~14'h0F0F, ~(8'hF0 ^ 8'h3C)}, "status word");
      $display("status test done");
   endtask
   task automatic testAlert();
      frame(24, {24'h0, CMD_WAKE_PROG, 16'h00FF});
      check(intOe_n, 1'b1, "alert idle");
      drv();
      progAboveRef[0] = ~progAboveRef[0];
      waitAlert(1'b0);
      frame(24, 48'h0);
      check(rx[22], 1'b1, "alert bit");
      check(intOe_n, 1'b1, "alert released");
      host.start();
      drv();
      progAboveRef[1] = ~progAboveRef[1];
      host.shift(24, 48'h0, rx);
      host.stop();
      check(intOe_n, 1'b0, "alert kept");
      frame(24, 48'h0);
      check(intOe_n, 1'b1, "alert released again");
      $display("alert test done");
   endtask
   task automatic testChain();
      frame(48, {24'h123456, CMD_CUR_PROG, 16'h0096});
      check(currentProg, 8'h96, "chained write");
      check(rx[23:0], 24'h123456, "chain pass-through");
      $display("chain test done");
   endtask
   task automatic sleepNow();
      drv();
      sleepRequest = 1'b1;
      drv();
      sleepRequest = 1'b0;
      repeat (6) @(posedge clk_sys);
      check({normalMode, wakeOe_n}, 2'b01, "asleep");
   endtask
   task automatic wakeBy(input int k);
      sleepNow();
      drv();
      case (k)
         0: intTimerExpired = 1'b1;
         1: wakeExt = 1'b0;
         2: host.start();
         3: intExt = 1'b0;
         default: progAboveRef = ~progAboveRef;
      endcase
      drv();
      intTimerExpired = 1'b0;
      repeat (10) @(posedge clk_sys);
      check({normalMode, wakeOe_n}, 2'b10, "woken");
      if (k == 2)
         host.stop();
      wakeExt = 1'b1;
      intExt = 1'b1;
   endtask
   task automatic testPower();
      check(soEnable_n, 1'b1, "idle released");
      drv();
      vddPresent = 1'b0;
      repeat (10) @(posedge clk_sys);
      check(normalMode, 1'b1, "normal kept");
      host.start();
      check(soEnable_n, 1'b1, "no output unpowered");
      host.shift(24, {24'h0, CMD_CUR_PROG, 16'h0022}, rx);
      host.stop();
      check(currentProg, 8'h96, "unpowered write refused");
      sleepNow();
      frame(24, 48'h0);
      drv();
      intExt = 1'b0;
      repeat (10) @(posedge clk_sys);
      check(normalMode, 1'b0, "select and alert ignored");
      intExt = 1'b1;
      wakeBy(0);
      drv();
      vddPresent = 1'b1;
      repeat (6) @(posedge clk_sys);
      for (int k = 1; k < 5; k++)
         wakeBy(k);
      $display("power test done");
   endtask
   initial begin
      reset_n = 1'b0;
      vddPresent = 1'b1;
      progAboveRef = '0;
      groundAboveRef = '1;
      thermalFlag = 1'b0;
      sleepRequest = 1'b0;
      intTimerExpired = 1'b0;
      intExt = 1'b1;
      wakeExt = 1'b1;
      failures = 0;
      tests_run = 0;
      repeat (2) @(posedge clk_sys);
      check({normalMode, wakeOe_n, batGndSelect, wakeEnProg}, {2'b10, BG_RESET, WAKE_PROG_RESET}, "reset");
      check({wakeEnGnd, currentProg}, {WAKE_GND_RESET, CUR_PROG_RESET}, "reset");
      check(currentGnd, CUR_GND_RESET, "reset");
      #1 reset_n = 1'b1;
      repeat (10) @(posedge clk_sys);
      frame(24, 48'h0);
      check(intOe_n, 1'b1, "first clear");
      testWrites();
      testStatus();
      testAlert();
      testChain();
      testPower();
      complete_run();
   end
endmodule
`default_nettype wire
